// file: ebsh_arbiter.v
// External bus control: power-down, idle insertion, sizing, hold and arbitration.
// How it works
// R01 - Idle refresh interval with no access puts the memory in power-down.
// R02 - Clock enable drops together with the refresh command.
// R03 - One wake-up state raises clock enable before the next refresh.
// R04 - After such a refresh with no access, power-down returns.
// R05 - Access during power-down gets a wake-up state, then stays awake.
// R06 - After a read, insert that block's programmed idle count.
// R07 - Idle states hold address, direction, lanes; float data; strobes inactive.
// R08 - A 32-bit single on a 16-bit block runs A1=0 then A1=1.
// R09 - A four-word burst on 16 bits runs eight commands, A3..A1 0 to 7.
// R10 - Split I/O or static cycles move the low half first.
// R11 - Hold request taken one clock later, then one pre-hold idle clock; code takes it four clocks later.
// R12 - Hold state asserts acknowledge and floats bus outputs.
// R13 - Entering hold clears the open page record.
// R14 - The non-maskable interrupt never ends an active hold.
// R15 - Priority: lock, refresh equal hold, transfer engine, core; code: refresh, lock, hold, transfer engine, buffer, core.
// R16 - No hold grant between locked read and locked write.
// R17 - Refresh still runs during a lock sequence.
// R18 - Hold allowed mid-transfer except between its read and write halves.
// R19 - Refresh beats a demand-mode transfer.
// R20 - Up to seven refreshes queue during hold, run after release.
// R21 - Four-entry write buffer stalls stores only when full; internal bypass.
// R22 - Buffer drains before uncached or missed loads and ordered instructions.
// R23 - Hold ends only after the request is withdrawn.
`timescale 1ns/1ps
`include "ebsh_consts.vh"
module ebsh_arbiter #(
    parameter DW = 32
) (
    input wire clk,
    input wire rst_n,
    input wire hold_request_n,
    input wire nmi_n,
    input wire lock_read_done,
    input wire lock_active,
    input wire refresh_tick,
    input wire dma_req,
    input wire dma_demand,
    input wire dma_mid_xfer,
    input wire [22:0] dma_addr,
    input wire dma_write,
    input wire dma_is_sdram,
    input wire [2:0] dma_block,
    input wire dma_narrow,
    input wire dma_burst,
    input wire cpu_req,
    input wire [22:0] cpu_addr,
    input wire cpu_write,
    input wire cpu_is_sdram,
    input wire [2:0] cpu_block,
    input wire cpu_narrow,
    input wire cpu_burst,
    input wire st_valid,
    input wire st_internal,
    input wire [22:0] st_addr,
    input wire [31:0] st_data,
    input wire [2:0] st_block,
    input wire st_narrow,
    input wire drain_req,
    input wire [23:0] read_idle_count,
    output reg st_stall,
    output reg drain_done,
    output reg cpu_ack,
    output reg dma_ack,
    output reg hold_acknowledge_n,
    output reg bus_oe,
    output reg data_oe,
    output reg [31:0] data_out,
    output reg [22:0] addr_out,
    output reg rd_wr_n,
    output reg [3:0] byte_lane_n,
    output reg cycle_start_strobe_n,
    output reg [7:0] block_select_n,
    output reg memory_read_strobe_n,
    output reg memory_write_strobe_n,
    output reg io_read_strobe_n,
    output reg io_write_strobe_n,
    output reg sdram_cke,
    output reg sdram_refresh_cmd,
    output reg page_open
);
    localparam S_IDLE = 8'h01;
    localparam S_WAKE = 8'h02;
    localparam S_XFER = 8'h04;
    localparam S_RIDL = 8'h08;
    localparam S_PREH = 8'h10;
    localparam S_HOLD = 8'h20;
    localparam S_RFSH = 8'h40;
    localparam S_ACPT = 8'h80;

    reg [7:0] st_r;
    reg [7:0] st_nxt;
    reg [2:0] hr_sync_r;
    reg hold_req_r;
    reg [2:0] rfq_r;
    reg pd_ok_r;
    reg acc_since_rf_r;
    reg [2:0] gnt_r;
    reg [2:0] beat_r;
    reg [2:0] beat_last_r;
    reg [2:0] idle_cnt_r;
    reg cur_write_r;
    reg cur_sdram_r;
    reg wake_for_rf_r;
    reg wb_new_r;
    reg [2:0] cur_block_r;
    reg [`EBSH_WB_AW:0] wb_cnt_r;
    reg [`EBSH_WB_AW-1:0] wb_wp_r;
    reg [`EBSH_WB_AW-1:0] wb_rp_r;
    wire [54:0] wb_rdata;
    wire wb_push;
    wire wb_pop;
    wire wb_empty;
    wire wb_full;
    wire hold_ok;
    wire rf_pend;
    reg [2:0] pick;
    reg [22:0] pick_addr;
    reg pick_write;
    reg pick_sdram;
    reg [2:0] pick_block;
    reg pick_narrow;
    reg pick_burst;
    reg [31:0] pick_data;
    reg [3:0] lanes_nxt;

    assign wb_empty = (wb_cnt_r == 0);
    assign wb_full = (wb_cnt_r == `EBSH_WB_DEPTH);
    // R21 store buffering
    assign wb_push = st_valid && !st_internal && !wb_full;
    assign wb_pop = (st_r == S_IDLE) && (pick == `EBSH_GNT_WB) && !wb_empty;
    // A tick in this very cycle already counts, so it beats a same-cycle transfer.
    assign rf_pend = (rfq_r != 3'h0) || refresh_tick;
    // R16 lock window
    // R18 transfer window
    assign hold_ok = !(lock_read_done && lock_active) && !dma_mid_xfer;

    ebsh_wbuf_mem #(.DW(55), .AW(`EBSH_WB_AW)) u_wbuf (
        .clk(clk),
        .we(wb_push),
        .waddr(wb_wp_r),
        .wdata({st_narrow, st_block, st_addr[22:0], st_data[27:0]}),
        .raddr(wb_rp_r),
        .rdata(wb_rdata)
    );

    // R15 fixed priority
    // R17 refresh under lock
    // R19 refresh over demand
    always @*
    begin
        pick = `EBSH_GNT_NONE;
        if (lock_active && cpu_req)
            pick = rf_pend ? `EBSH_GNT_RFSH : `EBSH_GNT_LOCK;
        else if (rf_pend)
            pick = `EBSH_GNT_RFSH;
        else if (hold_req_r && hold_ok)
            pick = `EBSH_GNT_HOLD;
        else if (dma_req && (dma_demand || !hold_req_r))
            pick = `EBSH_GNT_DMA;
        else if (!wb_empty && !wb_new_r)
            pick = `EBSH_GNT_WB;
        else if (cpu_req && !(drain_req && !wb_empty))
            pick = `EBSH_GNT_CPU;
    end

    always @*
    begin
        pick_addr = cpu_addr;
        pick_write = cpu_write;
        pick_sdram = cpu_is_sdram;
        pick_block = cpu_block;
        pick_narrow = cpu_narrow;
        pick_burst = cpu_burst;
        pick_data = 32'h00000000;
        if (pick == `EBSH_GNT_DMA)
        begin
            pick_addr = dma_addr;
            pick_write = dma_write;
            pick_sdram = dma_is_sdram;
            pick_block = dma_block;
            pick_narrow = dma_narrow;
            pick_burst = dma_burst;
        end
        else if (pick == `EBSH_GNT_WB)
        begin
            pick_addr = wb_rdata[50:28];
            pick_write = 1'b1;
            pick_sdram = (wb_rdata[53:51] == 3'h0);
            pick_block = wb_rdata[53:51];
            pick_narrow = wb_rdata[54];
            pick_burst = 1'b0;
            pick_data = {4'h0, wb_rdata[27:0]};
        end
    end

    always @*
    begin
        st_nxt = st_r;
        case (st_r)
            S_IDLE:
            begin
                if (pick == `EBSH_GNT_HOLD)
                    st_nxt = S_ACPT;
                else if (pick == `EBSH_GNT_RFSH)
                    st_nxt = pd_ok_r ? S_WAKE : S_RFSH;
                else if (pick != `EBSH_GNT_NONE)
                    st_nxt = (pick_sdram && pd_ok_r) ? S_WAKE : S_XFER;
            end
            S_WAKE: st_nxt = wake_for_rf_r ? S_RFSH : S_XFER;
            S_XFER:
                if (beat_r == beat_last_r)
                    st_nxt = (!cur_write_r && idle_cnt_r != 3'h0) ? S_RIDL : S_IDLE;
            S_RIDL: if (idle_cnt_r == 3'h1) st_nxt = S_IDLE;
            // R11 accept then pre-hold
            S_ACPT: st_nxt = S_PREH;
            S_PREH: st_nxt = S_HOLD;
            // R14 no exit on interrupt
            // R23 wait for withdrawal
            S_HOLD: if (!hold_req_r) st_nxt = S_IDLE;
            S_RFSH: st_nxt = S_IDLE;
            default: st_nxt = S_IDLE;
        endcase
    end

    always @*
    begin
        lanes_nxt = 4'h0;
        if (pick_narrow)
            lanes_nxt = 4'hc;
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            hr_sync_r <= 3'h0;
        else
            hr_sync_r <= {hr_sync_r[1:0], ~hold_request_n};
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= S_IDLE;
            hold_req_r <= 1'b0;
            rfq_r <= 3'h0;
            pd_ok_r <= 1'b0;
            acc_since_rf_r <= 1'b1;
            gnt_r <= `EBSH_GNT_NONE;
            beat_r <= 3'h0;
            beat_last_r <= 3'h0;
            idle_cnt_r <= 3'h0;
            cur_write_r <= 1'b0;
            cur_sdram_r <= 1'b0;
            wake_for_rf_r <= 1'b0;
            wb_new_r <= 1'b0;
            cur_block_r <= 3'h0;
            wb_cnt_r <= 3'h0;
            wb_wp_r <= 2'h0;
            wb_rp_r <= 2'h0;
            st_stall <= 1'b0;
            drain_done <= 1'b0;
            cpu_ack <= 1'b0;
            dma_ack <= 1'b0;
            hold_acknowledge_n <= 1'b1;
            bus_oe <= 1'b1;
            data_oe <= 1'b0;
            data_out <= 32'h00000000;
            addr_out <= `EBSH_ADDR_RST;
            rd_wr_n <= 1'b1;
            byte_lane_n <= 4'hf;
            cycle_start_strobe_n <= 1'b1;
            block_select_n <= 8'hff;
            memory_read_strobe_n <= 1'b1;
            memory_write_strobe_n <= 1'b1;
            io_read_strobe_n <= 1'b1;
            io_write_strobe_n <= 1'b1;
            sdram_cke <= 1'b1;
            sdram_refresh_cmd <= 1'b0;
            page_open <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            if (hr_sync_r[2] == hr_sync_r[1])
                hold_req_r <= hr_sync_r[2];
            cpu_ack <= 1'b0;
            dma_ack <= 1'b0;
            sdram_refresh_cmd <= 1'b0;
            cycle_start_strobe_n <= 1'b1;
            drain_done <= drain_req && wb_empty;
            // R21 stall only when full
            st_stall <= st_valid && !st_internal && wb_full;
            wb_cnt_r <= wb_cnt_r + {2'b00, wb_push} - {2'b00, wb_pop};
            if (wb_push)
                wb_wp_r <= wb_wp_r + 1'b1;
            // A store into an empty buffer reaches the registered read data a cycle late.
            wb_new_r <= wb_push && wb_empty;
            if (wb_pop)
                wb_rp_r <= wb_rp_r + 1'b1;
            // R20 refresh queue
            if (refresh_tick && !(st_r == S_IDLE && pick == `EBSH_GNT_RFSH)
                && rfq_r != `EBSH_RFQ_MAX)
                rfq_r <= rfq_r + 3'h1;
            else if (!refresh_tick && st_r == S_IDLE && pick == `EBSH_GNT_RFSH)
                rfq_r <= rfq_r - 3'h1;
            if (st_r == S_IDLE && pick != `EBSH_GNT_NONE && pick != `EBSH_GNT_HOLD)
            begin
                gnt_r <= pick;
                wake_for_rf_r <= (pick == `EBSH_GNT_RFSH);
                cur_block_r <= pick_block;
                cur_write_r <= pick_write;
                cur_sdram_r <= pick_sdram;
                beat_r <= 3'h0;
                // R09 eight narrow burst beats
                // R08 two narrow single beats
                beat_last_r <= pick_burst ? (pick_narrow ? 3'h7 : 3'h3)
                                          : (pick_narrow ? 3'h1 : 3'h0);
                // R06 per-block idle count
                idle_cnt_r <= read_idle_count[pick_block*3 +: 3];
                addr_out <= pick_addr;
                rd_wr_n <= !pick_write;
                data_out <= pick_data;
                byte_lane_n <= lanes_nxt;
                block_select_n <= ~(8'h01 << pick_block);
                cpu_ack <= (pick == `EBSH_GNT_CPU) || (pick == `EBSH_GNT_LOCK);
                dma_ack <= (pick == `EBSH_GNT_DMA);
                if (pick != `EBSH_GNT_RFSH && pick_sdram)
                    acc_since_rf_r <= 1'b1;
            end
            // R03 wake-up raises enable
            // R05 wake before access
            if (st_r == S_IDLE && st_nxt == S_WAKE)
                sdram_cke <= 1'b1;
            // The memory is selected only once it has been awake for a full state.
            if (st_r == S_WAKE && !wake_for_rf_r)
            begin
                pd_ok_r <= 1'b0;
                block_select_n <= ~(8'h01 << cur_block_r);
            end
            if (st_nxt == S_RFSH && st_r != S_RFSH)
            begin
                sdram_refresh_cmd <= 1'b1;
                // R01 idle interval power-down
                // R02 enable drops with refresh
                // R04 re-enter after refresh
                sdram_cke <= !(!acc_since_rf_r || pd_ok_r);
                pd_ok_r <= !acc_since_rf_r || pd_ok_r;
                acc_since_rf_r <= 1'b0;
            end
            if (st_r == S_XFER)
            begin
                cycle_start_strobe_n <= 1'b0;
                memory_read_strobe_n <= cur_write_r;
                memory_write_strobe_n <= !cur_write_r;
                data_oe <= cur_write_r;
                if (cur_sdram_r)
                    page_open <= 1'b1;
                // R10 low half first
                case (beat_last_r)
                    3'h7: addr_out[`EBSH_A1_BIT +: 3] <= beat_r;
                    3'h3: addr_out[`EBSH_A1_BIT +: 3] <= {beat_r[1:0], 1'b0};
                    3'h1: addr_out[`EBSH_A1_BIT] <= beat_r[0];
                    default: addr_out[`EBSH_A1_BIT] <= addr_out[`EBSH_A1_BIT];
                endcase
                beat_r <= beat_r + 3'h1;
            end
            // R07 idle bus levels
            // Strobes stand only for beats launched in the transfer state.
            if (st_r != S_XFER)
            begin
                data_oe <= 1'b0;
                memory_read_strobe_n <= 1'b1;
                memory_write_strobe_n <= 1'b1;
                io_read_strobe_n <= 1'b1;
                io_write_strobe_n <= 1'b1;
                if (st_nxt != S_XFER)
                    block_select_n <= 8'hff;
            end
            if (st_r == S_RIDL)
                idle_cnt_r <= idle_cnt_r - 3'h1;
            // R12 hold acknowledge and float
            // R13 clear open pages
            if (st_r == S_PREH)
            begin
                hold_acknowledge_n <= 1'b0;
                bus_oe <= 1'b0;
                data_oe <= 1'b0;
                page_open <= 1'b0;
            end
            if (st_r == S_HOLD && !hold_req_r)
            begin
                hold_acknowledge_n <= 1'b1;
                bus_oe <= 1'b1;
            end
        end
    end
endmodule // ebsh_arbiter

// file: ebsh_arbiter_checker.sv
// Concurrent checks on the ports of the external bus arbiter.
`timescale 1ns/1ps
module ebsh_arbiter_checker (
    input wire clk,
    input wire rst_n,
    input wire hold_request_n,
    input wire lock_active,
    input wire lock_read_done,
    input wire page_open,
    input wire dma_mid_xfer,
    input wire [23:0] read_idle_count,
    input wire hold_acknowledge_n,
    input wire bus_oe,
    input wire data_oe,
    input wire [22:0] addr_out,
    input wire cycle_start_strobe_n,
    input wire [7:0] block_select_n,
    input wire memory_read_strobe_n,
    input wire sdram_cke,
    input wire sdram_refresh_cmd
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    property p_hold_float;
        !hold_acknowledge_n |-> !bus_oe && !data_oe;
    endproperty
    a_hold_float: assert property (p_hold_float)
        else $error("bus driven while hold is acknowledged");
    property p_hold_release;
        $rose(hold_acknowledge_n) |-> hold_request_n && $past(hold_request_n);
    endproperty
    a_hold_release: assert property (p_hold_release)
        else $error("hold ended while still requested");
    property p_hold_stays;
        !hold_acknowledge_n && !hold_request_n |=> !hold_acknowledge_n;
    endproperty
    a_hold_stays: assert property (p_hold_stays)
        else $error("hold dropped while request still low");
    property p_hold_page;
        !hold_acknowledge_n |-> !page_open;
    endproperty
    a_hold_page: assert property (p_hold_page)
        else $error("open page record kept in hold");
    property p_lock_block;
        lock_active && lock_read_done && hold_acknowledge_n |=> hold_acknowledge_n;
    endproperty
    a_lock_block: assert property (p_lock_block)
        else $error("hold granted inside a lock sequence");
    property p_mid_block;
        dma_mid_xfer && hold_acknowledge_n |=> hold_acknowledge_n;
    endproperty
    a_mid_block: assert property (p_mid_block)
        else $error("hold granted between transfer halves");
    property p_cke_with_rfsh;
        $fell(sdram_cke) |-> sdram_refresh_cmd;
    endproperty
    a_cke_with_rfsh: assert property (p_cke_with_rfsh)
        else $error("clock enable fell without refresh");
    property p_wake_first;
        sdram_refresh_cmd |-> $past(sdram_cke);
    endproperty
    a_wake_first: assert property (p_wake_first)
        else $error("refresh issued without wake-up state");
    property p_sdram_awake;
        !block_select_n[0] |-> sdram_cke && $past(sdram_cke);
    endproperty
    a_sdram_awake: assert property (p_sdram_awake)
        else $error("memory selected while powered down");
    property p_read_idle;
        $rose(memory_read_strobe_n) && read_idle_count == {8{3'h2}} |->
            (cycle_start_strobe_n && !data_oe && &block_select_n && $stable(addr_out))[*2];
    endproperty
    a_read_idle: assert property (p_read_idle)
        else $error("idle states after read broken");
endmodule // ebsh_arbiter_checker

bind ebsh_arbiter ebsh_arbiter_checker u_chk (.clk(clk), .rst_n(rst_n),
    .hold_request_n(hold_request_n), .lock_active(lock_active),
    .lock_read_done(lock_read_done), .page_open(page_open),
    .dma_mid_xfer(dma_mid_xfer), .read_idle_count(read_idle_count),
    .hold_acknowledge_n(hold_acknowledge_n), .bus_oe(bus_oe), .data_oe(data_oe),
    .addr_out(addr_out), .cycle_start_strobe_n(cycle_start_strobe_n),
    .block_select_n(block_select_n), .memory_read_strobe_n(memory_read_strobe_n),
    .sdram_cke(sdram_cke), .sdram_refresh_cmd(sdram_refresh_cmd));

// file: ebsh_arbiter_tb.sv
// Self-checking testbench for the external bus arbiter.
`timescale 1ns/1ps
module ebsh_arbiter_tb;
    reg clk = 0, rst_n = 0, nmi_n = 1, lock_read_done = 0, lock_active = 0, refresh_tick = 0;
    reg dma_req = 0, dma_demand = 0, dma_mid_xfer = 0, dma_write = 0, dma_is_sdram = 0;
    reg dma_narrow = 0, dma_burst = 0, cpu_req = 0, cpu_write = 0, cpu_is_sdram = 0;
    reg cpu_narrow = 0, cpu_burst = 0, st_valid = 0, st_internal = 0, st_narrow = 0;
    reg drain_req = 0, pm_go = 0;
    reg [22:0] dma_addr = 23'h000040, cpu_addr = 23'h000000, st_addr = 23'h000100;
    reg [2:0] dma_block = 3'h3, cpu_block = 3'h2, st_block = 3'h2;
    reg [31:0] st_data = 32'h0a5c3e71;
    reg [23:0] read_idle_count = {8{3'h2}};
    reg [7:0] pm_len = 8'h08;
    reg [31:0] wr_data = 32'h00000000;
    reg [3:0] lanes_seen = 4'h0;
    reg rw_seen = 1'b0;
    wire st_stall, drain_done, cpu_ack, dma_ack, hold_acknowledge_n, bus_oe, data_oe, rd_wr_n;
    wire cycle_start_strobe_n, memory_read_strobe_n, memory_write_strobe_n, io_read_strobe_n;
    wire io_write_strobe_n, sdram_cke, sdram_refresh_cmd, page_open, hold_request_n, pm_ack;
    wire [31:0] data_out;
    wire [22:0] addr_out;
    wire [3:0] byte_lane_n;
    wire [7:0] block_select_n;
    integer bad_count = 0, samples_checked = 0, cyc = 0, rf_cnt = 0, i, k, m, rf0;
    logic [2:0] beats[$];
    time t_rf, t_dma, t_cpu, t0;

    ebsh_arbiter uut (.clk, .rst_n, .hold_request_n, .nmi_n, .lock_read_done, .lock_active,
        .refresh_tick, .dma_req, .dma_demand, .dma_mid_xfer, .dma_addr, .dma_write,
        .dma_is_sdram, .dma_block, .dma_narrow, .dma_burst, .cpu_req, .cpu_addr, .cpu_write,
        .cpu_is_sdram, .cpu_block, .cpu_narrow, .cpu_burst, .st_valid, .st_internal, .st_addr,
        .st_data, .st_block, .st_narrow, .drain_req, .read_idle_count, .st_stall, .drain_done,
        .cpu_ack, .dma_ack, .hold_acknowledge_n, .bus_oe, .data_oe, .data_out, .addr_out,
        .rd_wr_n, .byte_lane_n, .cycle_start_strobe_n, .block_select_n, .memory_read_strobe_n,
        .memory_write_strobe_n, .io_read_strobe_n, .io_write_strobe_n, .sdram_cke,
        .sdram_refresh_cmd, .page_open);
    ebsh_ext_master pm (.clk, .go(pm_go), .hold_len(pm_len), .hold_acknowledge_n,
        .hold_request_n, .got_ack(pm_ack));

    always #20 clk = ~clk;
    always @(negedge clk)
    begin
        if (cycle_start_strobe_n === 1'b0) beats.push_back(addr_out[2:0]);
        if (cycle_start_strobe_n === 1'b0) {lanes_seen, rw_seen} = {byte_lane_n, rd_wr_n};
        if (memory_write_strobe_n === 1'b0) wr_data = data_out;
        if (sdram_refresh_cmd === 1'b1) rf_cnt = rf_cnt + 1;
        if (sdram_refresh_cmd === 1'b1) t_rf = $time;
        if (dma_ack === 1'b1) t_dma = $time;
        if (cpu_ack === 1'b1) t_cpu = $time;
    end
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            bad_count = bad_count + 1;
            end_sim;
        end
    end

    task end_sim;
    begin
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    task chkb(input string nm, input logic e, input logic g);
    begin
        samples_checked = samples_checked + 1;
        if (g !== e)
        begin
            bad_count = bad_count + 1;
            $display("MISMATCH %s exp %b got %b", nm, e, g);
        end
    end
    endtask
    task chkn(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
        samples_checked = samples_checked + 1;
        if (g !== e)
        begin
            bad_count = bad_count + 1;
            $display("MISMATCH %s exp %0h got %0h", nm, e, g);
        end
    end
    endtask
    task tick;
    begin
        @(negedge clk) refresh_tick = 1;
        @(negedge clk) refresh_tick = 0;
        repeat (30) @(negedge clk);
    end
    endtask
    task cpu_op(input [2:0] blk, input nar, input bur, input sd);
    begin
        @(negedge clk);
        {cpu_block, cpu_narrow, cpu_burst, cpu_is_sdram} = {blk, nar, bur, sd};
        beats.delete();
        cpu_req = 1;
        for (i = 0; i < 200 && cpu_ack !== 1'b1; i = i + 1) @(negedge clk);
        cpu_req = 0;
        repeat (40) @(negedge clk);
    end
    endtask
    task go_hold(input [7:0] len);
    begin
        pm_len = len;
        @(negedge clk) pm_go = 1;
        @(negedge clk) pm_go = 0;
    end
    endtask
    task t_power;
    begin
        tick;
        tick;
        chkb("cke_idle", 0, sdram_cke);
        tick;
        chkb("cke_again", 0, sdram_cke);
        cpu_op(3'h0, 0, 0, 1);
        chkb("cke_woken", 1, sdram_cke);
        tick;
        chkb("cke_stays", 1, sdram_cke);
    end
    endtask
    task t_size;
    begin
        for (m = 0; m < 2; m = m + 1)
        begin
            cpu_write = m[0];
            cpu_op(3'h2, 1, 0, 0);
            chkn("single_beats", 2, beats.size());
            for (k = 0; k < 2; k = k + 1) chkn("single_a1", k, beats[k]);
            chkn("single_lanes", 4'hc, lanes_seen);
            chkb("single_dir", !m[0], rw_seen);
            cpu_op(3'h2, 1, 1, 0);
            chkn("burst_beats", 8, beats.size());
            for (k = 0; k < 8; k = k + 1) chkn("burst_addr", k, beats[k]);
        end
    end
    endtask
    task t_block;
    begin
        chkb("page_set", 1, page_open);
        for (m = 0; m < 2; m = m + 1)
        begin
            @(negedge clk) {lock_active, lock_read_done, dma_mid_xfer} = {m == 0, m == 0, m == 1};
            go_hold(8'h08);
            repeat (15) @(negedge clk);
            chkb("hack_refused", 1, hold_acknowledge_n);
            {lock_active, lock_read_done, dma_mid_xfer} = 3'h0;
            for (i = 0; i < 30 && hold_acknowledge_n !== 1'b0; i = i + 1) @(negedge clk);
            chkb("hack_late", 0, hold_acknowledge_n);
            chkb("page_clr", 0, page_open);
            repeat (30) @(negedge clk);
        end
    end
    endtask
    task t_hold;
    begin
        go_hold(8'h50);
        for (i = 0; i < 30 && hold_acknowledge_n !== 1'b0; i = i + 1) @(negedge clk);
        chkb("hack", 0, hold_acknowledge_n);
        chkb("bus_float", 0, bus_oe);
        @(negedge clk) nmi_n = 0;
        repeat (3) @(negedge clk);
        nmi_n = 1;
        chkb("hack_nmi", 0, hold_acknowledge_n);
        rf0 = rf_cnt;
        for (k = 0; k < 9; k = k + 1) tick_fast();
        chkn("rf_in_hold", rf0, rf_cnt);
        for (k = 0; k < 4; k = k + 1)
        begin
            chkb("no_stall", 0, st_stall);
            @(negedge clk) {st_valid, st_addr} = {1'b1, 23'h000100 + 23'(k * 2)};
            @(negedge clk) st_valid = 0;
        end
        @(negedge clk) st_valid = 1;
        @(negedge clk) st_valid = 0;
        chkb("stall_full", 1, st_stall);
        for (i = 0; i < 200 && hold_acknowledge_n !== 1'b1; i = i + 1) @(negedge clk);
        chkb("hack_end", 1, hold_acknowledge_n);
        beats.delete();
        drain_req = 1;
        for (i = 0; i < 400 && drain_done !== 1'b1; i = i + 1) @(negedge clk);
        drain_req = 0;
        chkb("drained", 1, drain_done);
        repeat (40) @(negedge clk);
        chkn("rf_after", rf0 + 7, rf_cnt);
        chkn("wb_beats", 4, beats.size());
        chkn("wb_data", 32'h0a5c3e71, wr_data);
    end
    endtask
    task tick_fast;
    begin
        @(negedge clk) refresh_tick = 1;
        @(negedge clk) refresh_tick = 0;
    end
    endtask
    task t_prio;
    begin
        @(negedge clk) {refresh_tick, dma_req, dma_demand, cpu_req, cpu_block} = 7'h7a;
        t0 = $time;
        @(negedge clk) refresh_tick = 0;
        for (i = 0; i < 200 && dma_ack !== 1'b1; i = i + 1) @(negedge clk);
        dma_req = 0;
        for (i = 0; i < 200 && cpu_ack !== 1'b1; i = i + 1) @(negedge clk);
        cpu_req = 0;
        repeat (40) @(negedge clk);
        chkb("rfsh_first", 1, t_rf > t0 && t_rf < t_dma);
        chkb("dma_first", 1, t_dma > t0 && t_dma < t_cpu);
    end
    endtask

    initial
    begin
        repeat (8) @(negedge clk);
        rst_n = 1;
        chkb("cke_rst", 1, sdram_cke);
        chkb("hack_rst", 1, hold_acknowledge_n);
        repeat (4) @(negedge clk);
        t_power;
        t_size;
        t_block;
        t_hold;
        t_prio;
        end_sim;
    end
endmodule // ebsh_arbiter_tb

// file: ebsh_consts.vh
// Constants for the external bus sizing, hold and arbitration block.
`ifndef EBSH_CONSTS_VH
`define EBSH_CONSTS_VH
`define EBSH_RFQ_MAX 3'h7
`define EBSH_WB_DEPTH 4
`define EBSH_WB_AW 2
`define EBSH_IDLE_W 3
`define EBSH_A1_BIT 0
`define EBSH_ADDR_RST 23'h000000
`define EBSH_GNT_NONE 3'h0
`define EBSH_GNT_LOCK 3'h1
`define EBSH_GNT_RFSH 3'h2
`define EBSH_GNT_HOLD 3'h3
`define EBSH_GNT_DMA 3'h4
`define EBSH_GNT_CPU 3'h5
`define EBSH_GNT_WB 3'h6
`endif

// file: ebsh_ext_master.sv
// Behavioural external master that borrows the bus through the hold handshake.
`timescale 1ns/1ps
module ebsh_ext_master (
    input wire clk,
    input wire go,
    input wire [7:0] hold_len,
    input wire hold_acknowledge_n,
    output reg hold_request_n,
    output reg got_ack
);
    integer i;
    initial
    begin
        hold_request_n = 1'b1;
        got_ack = 1'b0;
    end
    always @(posedge go)
    begin
        @(negedge clk);
        hold_request_n <= 1'b0;
        got_ack = 1'b0;
        for (i = 0; i < 300 && !got_ack; i = i + 1)
        begin
            @(posedge clk);
            got_ack = (hold_acknowledge_n === 1'b0);
        end
        repeat (hold_len) @(posedge clk);
        @(negedge clk);
        hold_request_n <= 1'b1;
    end
endmodule // ebsh_ext_master

// file: ebsh_wbuf_mem.v
// Four-entry write buffer storage with registered read data.
`timescale 1ns/1ps
`include "ebsh_consts.vh"
module ebsh_wbuf_mem #(
    parameter DW = 55,
    parameter AW = 2
) (
    input wire clk,
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [DW-1:0] wdata,
    input wire [AW-1:0] raddr,
    output reg [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    always @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // ebsh_wbuf_mem
